// >>> core/ppc_pkg.sv
// Constants and register map of the port 0 pin control block
// Functional notes
// - Each data write stores into the output latch, kept until next write.
// - Output latches clear to zero on reset.
// - Port mode, output direction: latch drives pin, reads return latch.
// - Input direction: reads return sampled pin level; pin is not driven.
// - Alternate mode: peripheral owns pin; latch writes still stored.
// - One direction bit per pin, 0 output, 1 input.
// - One port/alternate bit per pin, 0 port, 1 alternate.
// - Function-select bit picks among two or more alternate functions.
// - Expansion bit plus function bit form two-bit function code.
// - Output-type register, reset 00h: 0 push-pull, 1 open-drain.
// - Open-drain setting applies only in output direction.
// - Data register supports single-bit and whole-register access.
// - Five pins in the large variant, three in the small ones.
// - Pin functions: NMI, irq/trigger/1Hz, irq/clocks, irq/debug reset, irq.
// - Pin 3 codes: 00 irq, 01 trigger, 11 one-hertz, 10 prohibited.
// - Pin 4 codes: 00 irq, 01 divided clock, 10 clock, 11 prohibited.
// - Debug mode bit 1 makes pin 5 the debug reset input.
package ppc_pkg;
  localparam logic [7:0] PPC_DATA_OFS = 8'h00;
  localparam logic [7:0] PPC_DIR_OFS = 8'h04;
  localparam logic [7:0] PPC_ALT_OFS = 8'h08;
  localparam logic [7:0] PPC_FSEL_OFS = 8'h0c;
  localparam logic [7:0] PPC_FEXT_OFS = 8'h10;
  localparam logic [7:0] PPC_OTYPE_OFS = 8'h14;
  localparam logic [7:0] PPC_DBG_OFS = 8'h18;
  localparam logic [7:0] PPC_SET_OFS = 8'h1c;
  localparam logic [7:0] PPC_CLR_OFS = 8'h20;
  localparam logic [7:0] PPC_MASK_LARGE = 8'h7c;
  localparam logic [7:0] PPC_MASK_SMALL = 8'h2c;
  localparam logic [7:0] PPC_MASK_FSEL = 8'h18;
  localparam logic [7:0] PPC_DATA_RST = 8'h00;
  localparam logic [7:0] PPC_DIR_RST = 8'hff;
  localparam logic [7:0] PPC_ALT_RST = 8'h00;
  localparam logic [7:0] PPC_FSEL_RST = 8'h00;
  localparam logic [7:0] PPC_FEXT_RST = 8'h00;
  localparam logic [7:0] PPC_OTYPE_RST = 8'h00;
  localparam logic PPC_DBG_RST = 1'b1;
  localparam int PPC_PIN3 = 3;
  localparam int PPC_PIN4 = 4;
  localparam int PPC_PIN5 = 5;
  typedef enum logic [1:0] {
    PPC_FN_IRQ = 2'b00,
    PPC_FN_F1 = 2'b01,
    PPC_FN_F2 = 2'b10,
    PPC_FN_F3 = 2'b11
  } ppc_fn_t;
endpackage

// >>> core/ppc_sync.sv
// Two-flop synchroniser for the pin inputs
module ppc_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [7:0] d_i,
  output logic [7:0] q_o
);
  logic [7:0] meta_q;
  logic [7:0] sync_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

// >>> core/ppc_pad.sv
// Output driver of one pin: push-pull or open-drain
module ppc_pad (
  // Control
  input wire logic drive_i,
  input wire logic value_i,
  input wire logic open_drain_i,
  // Pad
  output logic out_o,
  output logic oe_n_o
);
  logic od_active;

  assign od_active = open_drain_i;
  // Open-drain only pulls low; a high value releases the pin
  assign out_o = od_active ? 1'b0 : value_i;
  assign oe_n_o = ~(drive_i & (~od_active | ~value_i));
endmodule

// >>> core/ppc_top.sv
// Port 0 pin control: Wishbone registers, pin muxing and alternate functions
//
// Local design decisions: register access over Wishbone and the register offsets.
module ppc_top #(
  parameter bit LARGE_PKG = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_n_o,
  // Alternate-function peripheral outputs
  input wire logic one_hertz_clock_i,
  input wire logic divided_clock_i,
  input wire logic calendar_clock_i,
  // Alternate-function inputs to peripherals
  output logic nmi_in_o,
  output logic ext_irq_in_zero_o,
  output logic ext_irq_in_one_o,
  output logic ext_irq_in_two_o,
  output logic ext_irq_in_three_o,
  output logic converter_trigger_in_o,
  output logic debug_reset_in_o,
  output logic debug_mode_enable_o
);
  logic [7:0] pin_data_latch_q;
  logic [7:0] pin_direction_select_q;
  logic [7:0] port_or_alternate_select_q;
  logic [7:0] alt_function_select_q;
  logic [7:0] alt_function_select_ext_q;
  logic [7:0] output_type_select_q;
  logic debug_mode_enable_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] pin_sync;

  // Implemented pins of this variant
  logic [7:0] impl_mask;
  logic [7:0] fsel_mask;
  assign impl_mask = LARGE_PKG ? ppc_pkg::PPC_MASK_LARGE : ppc_pkg::PPC_MASK_SMALL;
  assign fsel_mask = impl_mask & ppc_pkg::PPC_MASK_FSEL;

  // Bus decode
  logic req;
  logic wr_lane0;
  logic wr_data;
  logic wr_dir;
  logic wr_alt;
  logic wr_fsel;
  logic wr_fext;
  logic wr_otype;
  logic wr_dbg;
  logic wr_set;
  logic wr_clr;
  logic [7:0] wbyte;
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // Address hits, shared by the write strobes and the read mux
  // Address bits 1:0 are ignored: every register sits on a word boundary
  logic hit_data;
  logic hit_dir;
  logic hit_alt;
  logic hit_fsel;
  logic hit_fext;
  logic hit_otype;
  logic hit_dbg;
  logic hit_set;
  logic hit_clr;

  assign hit_data = hit(wb_adr_i, ppc_pkg::PPC_DATA_OFS);
  assign hit_dir = hit(wb_adr_i, ppc_pkg::PPC_DIR_OFS);
  assign hit_alt = hit(wb_adr_i, ppc_pkg::PPC_ALT_OFS);
  assign hit_fsel = hit(wb_adr_i, ppc_pkg::PPC_FSEL_OFS);
  assign hit_fext = hit(wb_adr_i, ppc_pkg::PPC_FEXT_OFS);
  assign hit_otype = hit(wb_adr_i, ppc_pkg::PPC_OTYPE_OFS);
  assign hit_dbg = hit(wb_adr_i, ppc_pkg::PPC_DBG_OFS);
  assign hit_set = hit(wb_adr_i, ppc_pkg::PPC_SET_OFS);
  assign hit_clr = hit(wb_adr_i, ppc_pkg::PPC_CLR_OFS);

  // Writes need lane 0; the other lanes hold no register bits
  assign wr_data = wr_lane0 & hit_data;
  assign wr_dir = wr_lane0 & hit_dir;
  assign wr_alt = wr_lane0 & hit_alt;
  assign wr_fsel = wr_lane0 & hit_fsel;
  assign wr_fext = wr_lane0 & hit_fext;
  assign wr_otype = wr_lane0 & hit_otype;
  assign wr_dbg = wr_lane0 & hit_dbg;
  assign wr_set = wr_lane0 & hit_set;
  assign wr_clr = wr_lane0 & hit_clr;

  // Latch next value: whole write, or set/clear of every implemented bit written as one
  logic [7:0] latch_d;
  assign latch_d = wr_data ? ((wbyte & impl_mask) | (pin_data_latch_q & ~impl_mask))
                 : wr_set ? (pin_data_latch_q | (wbyte & impl_mask))
                 : wr_clr ? (pin_data_latch_q & ~(wbyte & impl_mask))
                 : pin_data_latch_q;

  // Next values of the configuration registers
  // Unimplemented bits are forced here, so they read back fixed and never reach a pin
  logic [7:0] dir_d;
  logic [7:0] alt_d;
  logic [7:0] fsel_d;
  logic [7:0] fext_d;
  logic [7:0] otype_d;
  assign dir_d = (wbyte & impl_mask) | ~impl_mask;
  assign alt_d = wbyte & impl_mask;
  assign fsel_d = wbyte & fsel_mask;
  assign fext_d = wbyte & fsel_mask;
  assign otype_d = wbyte & impl_mask;

  // Output latch: every write lands, whatever the pin mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_data_latch_q <= ppc_pkg::PPC_DATA_RST;
    else
      pin_data_latch_q <= latch_d;
  end

  // Direction: pins leave reset as inputs, so nothing is driven
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_direction_select_q <= ppc_pkg::PPC_DIR_RST;
    else if (wr_dir)
      pin_direction_select_q <= dir_d;
  end

  // Port or alternate-function operation
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_or_alternate_select_q <= ppc_pkg::PPC_ALT_RST;
    else if (wr_alt)
      port_or_alternate_select_q <= alt_d;
  end

  // Function select bit of the two-bit function code
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      alt_function_select_q <= ppc_pkg::PPC_FSEL_RST;
    else if (wr_fsel)
      alt_function_select_q <= fsel_d;
  end

  // Expansion bit of the two-bit function code
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      alt_function_select_ext_q <= ppc_pkg::PPC_FEXT_RST;
    else if (wr_fext)
      alt_function_select_ext_q <= fext_d;
  end

  // Output type: push-pull or open-drain
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      output_type_select_q <= ppc_pkg::PPC_OTYPE_RST;
    else if (wr_otype)
      output_type_select_q <= otype_d;
  end

  // Debug mode leaves reset set, so the debug reset pin is owned from the start
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      debug_mode_enable_q <= ppc_pkg::PPC_DBG_RST;
    else if (wr_dbg)
      debug_mode_enable_q <= wbyte[0];
  end

  // Pin input synchroniser
  ppc_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pin_i),
    .q_o(pin_sync)
  );

  // Data read: latch in output direction, pin level in input direction
  logic [7:0] data_rd;
  assign data_rd = ((pin_direction_select_q & pin_sync)
                 | (~pin_direction_select_q & pin_data_latch_q)) & impl_mask;

  // Register read mux; unmapped offsets and the set/clear words read as zero
  logic [7:0] rsel;
  assign rsel = hit_data ? data_rd
              : hit_dir ? pin_direction_select_q
              : hit_alt ? port_or_alternate_select_q
              : hit_fsel ? alt_function_select_q
              : hit_fext ? alt_function_select_ext_q
              : hit_otype ? output_type_select_q
              : hit_dbg ? {7'h00, debug_mode_enable_q}
              : 8'h00;

  // Read data stands with ack only; write acks carry zero
  logic [31:0] rdat_d;
  assign rdat_d = (req & ~wb_we_i) ? {24'h000000, rsel} : 32'h0000_0000;

  // Ack drops for a cycle after each access, so a held strobe is not taken twice
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  // Read data register, cleared between accesses
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_q <= 32'h0000_0000;
    else
      rdat_q <= rdat_d;
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Alternate function codes of pins 3 and 4
  ppc_pkg::ppc_fn_t fn3;
  ppc_pkg::ppc_fn_t fn4;
  assign fn3 = ppc_pkg::ppc_fn_t'({alt_function_select_ext_q[ppc_pkg::PPC_PIN3],
                                   alt_function_select_q[ppc_pkg::PPC_PIN3]});
  assign fn4 = ppc_pkg::ppc_fn_t'({alt_function_select_ext_q[ppc_pkg::PPC_PIN4],
                                   alt_function_select_q[ppc_pkg::PPC_PIN4]});

  logic [7:0] alt_mode;
  assign alt_mode = port_or_alternate_select_q & impl_mask;
  logic dbg_pin5;
  assign dbg_pin5 = debug_mode_enable_q;

  // Alternate-function outputs and their drive requests
  logic [7:0] alt_drive;
  logic [7:0] alt_value;
  assign alt_drive[3] = alt_mode[3] & (fn3 == ppc_pkg::PPC_FN_F3);
  assign alt_value[3] = one_hertz_clock_i;
  assign alt_drive[4] = alt_mode[4] & ((fn4 == ppc_pkg::PPC_FN_F1)
                      | (fn4 == ppc_pkg::PPC_FN_F2));
  assign alt_value[4] = (fn4 == ppc_pkg::PPC_FN_F1) ? divided_clock_i : calendar_clock_i;
  assign alt_drive[2] = 1'b0;
  assign alt_value[2] = 1'b0;
  assign alt_drive[7:5] = 3'b000;
  assign alt_value[7:5] = 3'b000;
  assign alt_drive[1:0] = 2'b00;
  assign alt_value[1:0] = 2'b00;

  // Peripheral inputs
  assign nmi_in_o = alt_mode[2] & pin_sync[2];
  assign ext_irq_in_zero_o = alt_mode[3] & (fn3 == ppc_pkg::PPC_FN_IRQ) & pin_sync[3];
  assign converter_trigger_in_o = alt_mode[3] & (fn3 == ppc_pkg::PPC_FN_F1) & pin_sync[3];
  assign ext_irq_in_one_o = alt_mode[4] & (fn4 == ppc_pkg::PPC_FN_IRQ) & pin_sync[4];
  assign ext_irq_in_two_o = alt_mode[5] & ~dbg_pin5 & pin_sync[5];
  assign ext_irq_in_three_o = alt_mode[6] & pin_sync[6];
  assign debug_reset_in_o = dbg_pin5 & pin_sync[5];
  assign debug_mode_enable_o = debug_mode_enable_q;

  // Per-pin drive selection
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_pin
      logic drv;
      logic val;
      logic port_drv;
      logic od;
      logic own_dbg;
      assign own_dbg = (g == ppc_pkg::PPC_PIN5) ? dbg_pin5 : 1'b0;
      assign port_drv = ~alt_mode[g] & ~pin_direction_select_q[g];
      // Alternate outputs need output direction too
      assign drv = impl_mask[g] & ~own_dbg & ~pin_direction_select_q[g]
                 & (port_drv | alt_drive[g]);
      assign val = alt_mode[g] ? alt_value[g] : pin_data_latch_q[g];
      assign od = output_type_select_q[g] & ~pin_direction_select_q[g];
      ppc_pad u_pad (
        .drive_i(drv),
        .value_i(val),
        .open_drain_i(od),
        .out_o(pin_o[g]),
        .oe_n_o(pin_oe_n_o[g])
      );
    end
  endgenerate
endmodule

// >>> testbench/ppc_ext_dev.sv
// External device model on the port 0 pins
module ppc_ext_dev (
  // Design pad side
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n_o,
  // Device side
  input wire logic [7:0] ext_val_i,
  input wire logic dbg_i,
  output logic [7:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ext_w;
  // Debug reset pin held low while debug mode is on
  assign ext_w = dbg_i ? (ext_val_i & 8'hdf) : ext_val_i;
  assign pin_i = (~pin_oe_n_o & pin_o) | (pin_oe_n_o & ext_w);
endmodule

// >>> testbench/ppc_top_monitor.sv
// Bus and pin checks on the port 0 pin control block
module ppc_top_monitor #(
  parameter bit LARGE_PKG = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n_o,
  input wire logic one_hertz_clock_i,
  input wire logic divided_clock_i,
  input wire logic calendar_clock_i,
  input wire logic nmi_in_o,
  input wire logic ext_irq_in_zero_o,
  input wire logic ext_irq_in_one_o,
  input wire logic ext_irq_in_two_o,
  input wire logic ext_irq_in_three_o,
  input wire logic converter_trigger_in_o,
  input wire logic debug_reset_in_o,
  input wire logic debug_mode_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] unused_w;
  assign unused_w = LARGE_PKG ? ~ppc_pkg::PPC_MASK_LARGE : ~ppc_pkg::PPC_MASK_SMALL;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ans_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_ONE: assert property (req_s |=> ans_s)
    else $error("ack not a single pulse after request");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_WR_DAT: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
    else $error("read data on write ack");
  AST_RD_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_RST_UNDRIVEN: assert property (disable iff (1'b0) rst_i |=> pin_oe_n_o == 8'hff)
    else $error("pin driven after reset");
  AST_UNUSED_PINS: assert property ((pin_oe_n_o & unused_w) == unused_w)
    else $error("unimplemented pin driven");
  AST_DBG_PIN: assert property (debug_mode_enable_o |-> pin_oe_n_o[5] && !ext_irq_in_two_o)
    else $error("debug pin not input only");
  AST_DBG_RST_IN: assert property (!debug_mode_enable_o |-> !debug_reset_in_o)
    else $error("debug reset fed outside debug mode");
  AST_P3_EXCL: assert property (!(ext_irq_in_zero_o && converter_trigger_in_o))
    else $error("two pin 3 functions at once");
endmodule
bind ppc_top ppc_top_monitor #(.LARGE_PKG(LARGE_PKG)) u_mon (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .pin_i(pin_i),
  .pin_o(pin_o),
  .pin_oe_n_o(pin_oe_n_o),
  .one_hertz_clock_i(one_hertz_clock_i),
  .divided_clock_i(divided_clock_i),
  .calendar_clock_i(calendar_clock_i),
  .nmi_in_o(nmi_in_o),
  .ext_irq_in_zero_o(ext_irq_in_zero_o),
  .ext_irq_in_one_o(ext_irq_in_one_o),
  .ext_irq_in_two_o(ext_irq_in_two_o),
  .ext_irq_in_three_o(ext_irq_in_three_o),
  .converter_trigger_in_o(converter_trigger_in_o),
  .debug_reset_in_o(debug_reset_in_o),
  .debug_mode_enable_o(debug_mode_enable_o)
);

// >>> testbench/test_ppc_top.sv
// Self-checking bench of the port 0 pin control block
module test_ppc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, pin_i, pin_o, pin_oe_n_o, ext_val = 8'hff;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h9e13df4c;
  logic nmi, irq0, irq1, irq2, irq3, trig, dbg_rst, dbg_en, e3, e4;
  logic [31:0] exp_q[$];
  logic [31:0] seen_v, exp_v;
  logic [3:0] wb_sel_i = 4'hf, sel_nxt = 4'hf;
  int err_count = 0, samples_checked = 0, cyc_cnt = 0;
  always #10 clk_i = ~clk_i;
  ppc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o), .one_hertz_clock_i(1'b1), .divided_clock_i(1'b0),
    .calendar_clock_i(1'b1), .nmi_in_o(nmi), .ext_irq_in_zero_o(irq0), .ext_irq_in_one_o(irq1),
    .ext_irq_in_two_o(irq2), .ext_irq_in_three_o(irq3), .converter_trigger_in_o(trig),
    .debug_reset_in_o(dbg_rst), .debug_mode_enable_o(dbg_en));
  ppc_ext_dev ext (.pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .ext_val_i(ext_val), .dbg_i(dbg_en),
    .pin_i(pin_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop(input bit hung);
    if (hung || exp_q.size() != 0)
      err_count++;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel_nxt;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // Read results are compared against the oldest note
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt > 2000)
      report_and_stop(1'b1);
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      check("read", wb_dat_o, exp_q.pop_front());
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ppc_pkg::PPC_DIR_OFS, 32'hff);
    rd(ppc_pkg::PPC_ALT_OFS, 32'h0);
    rd(ppc_pkg::PPC_FSEL_OFS, 32'h0);
    rd(ppc_pkg::PPC_FEXT_OFS, 32'h0);
    rd(ppc_pkg::PPC_OTYPE_OFS, 32'h0);
    rd(ppc_pkg::PPC_DBG_OFS, 32'h1);
    rd(ppc_pkg::PPC_DATA_OFS, 32'h5c);
    rd(8'h24, 32'h0);
    $display("reset test done");
    wb(1'b1, ppc_pkg::PPC_DBG_OFS, 32'h0);
    wb(1'b1, ppc_pkg::PPC_DIR_OFS, 32'h0);
    rd(ppc_pkg::PPC_DIR_OFS, 32'h83);
    rd(ppc_pkg::PPC_DATA_OFS, 32'h0);
    repeat (4)
    begin
      seed = xs(seed);
      wb(1'b1, ppc_pkg::PPC_DATA_OFS, seed);
      rd(ppc_pkg::PPC_DATA_OFS, {24'h0, seed[7:0] & 8'h7c});
      check("pins", {pin_oe_n_o, pin_o & 8'h7c}, {8'h83, seed[7:0] & 8'h7c});
    end
    wb(1'b1, ppc_pkg::PPC_DATA_OFS, 32'h0);
    wb(1'b1, ppc_pkg::PPC_SET_OFS, 32'h24);
    wb(1'b1, ppc_pkg::PPC_CLR_OFS, 32'h04);
    sel_nxt = 4'he;
    wb(1'b1, ppc_pkg::PPC_DATA_OFS, 32'hff);
    sel_nxt = 4'hf;
    rd(ppc_pkg::PPC_DATA_OFS, 32'h20);
    $display("output test done");
    wb(1'b1, ppc_pkg::PPC_OTYPE_OFS, 32'hff);
    rd(ppc_pkg::PPC_OTYPE_OFS, 32'h7c);
    wb(1'b1, ppc_pkg::PPC_DATA_OFS, 32'h54);
    check("drain", {24'h0, pin_oe_n_o}, 32'hd7);
    wb(1'b1, ppc_pkg::PPC_DIR_OFS, 32'hff);
    ext_val <= 8'h48;
    repeat (3) @(posedge clk_i);
    check("input", {24'h0, pin_oe_n_o}, 32'hff);
    rd(ppc_pkg::PPC_DATA_OFS, 32'h48);
    wb(1'b1, ppc_pkg::PPC_DATA_OFS, 32'h10);
    wb(1'b1, ppc_pkg::PPC_DIR_OFS, 32'h0);
    rd(ppc_pkg::PPC_DATA_OFS, 32'h10);
    wb(1'b1, ppc_pkg::PPC_OTYPE_OFS, 32'h0);
    wb(1'b1, ppc_pkg::PPC_DATA_OFS, 32'h0);
    ext_val <= 8'hff;
    $display("input test done");
    for (int c = 0; c < 4; c++)
    begin
      wb(1'b1, ppc_pkg::PPC_ALT_OFS, 32'h0);
      wb(1'b1, ppc_pkg::PPC_FSEL_OFS, c[0] ? 32'h18 : 32'h0);
      wb(1'b1, ppc_pkg::PPC_FEXT_OFS, c[1] ? 32'h18 : 32'h0);
      wb(1'b1, ppc_pkg::PPC_ALT_OFS, 32'h18);
      repeat (3) @(posedge clk_i);
      e3 = (c == 3);
      e4 = (c == 1) || (c == 2);
      seen_v = {8'h0, pin_oe_n_o, pin_o & ~pin_oe_n_o & 8'h18, 5'h0, trig, irq0, irq1};
      exp_v = {8'h0, 8'h83 | {3'h0, !e4, !e3, 3'h0}, {3'h0, e4 & (c == 2), e3, 3'h0}, 5'h0,
        c == 1, c == 0, c == 0};
      check("alt", seen_v, exp_v);
    end
    $display("alternate test done");
    wb(1'b1, ppc_pkg::PPC_DIR_OFS, 32'h44);
    wb(1'b1, ppc_pkg::PPC_ALT_OFS, 32'h44);
    wb(1'b1, ppc_pkg::PPC_DBG_OFS, 32'h1);
    repeat (3) @(posedge clk_i);
    seen_v = {26'h0, nmi, irq3, pin_oe_n_o[2], pin_oe_n_o[5], dbg_rst, irq2};
    check("dbg", seen_v, 32'h3c);
    wb(1'b1, ppc_pkg::PPC_DBG_OFS, 32'h0);
    wb(1'b1, ppc_pkg::PPC_ALT_OFS, 32'h64);
    repeat (3) @(posedge clk_i);
    check("irq2", {29'h0, irq2, dbg_rst, dbg_en}, 32'h4);
    $display("debug test done");
    wb(1'b1, ppc_pkg::PPC_DATA_OFS, 32'h7c);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("rst pins", {24'h0, pin_oe_n_o}, 32'hff);
    wb(1'b1, ppc_pkg::PPC_DIR_OFS, 32'h0);
    rd(ppc_pkg::PPC_DATA_OFS, 32'h0);
    rd(ppc_pkg::PPC_DBG_OFS, 32'h1);
    $display("second reset test done");
    report_and_stop(1'b0);
  end
endmodule
